// [tsdr_pkg.sv]
// tile status and debug register bank: shared offsets, fields, resets
// assumes an 8-bit processor status register number and 32-bit data
package tsdr_pkg;

  // ----------------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------------
  localparam logic [7:0] TSDR_TILE_BOOT_STATUS = 8'h03;
  localparam logic [7:0] TSDR_SECURITY_WORD_COPY = 8'h05;
  localparam logic [7:0] TSDR_RING_OSC_CONTROL = 8'h06;
  localparam logic [7:0] TSDR_RING_COUNT_TILE_CELL = 8'h07;
  localparam logic [7:0] TSDR_RING_COUNT_TILE_WIRE = 8'h08;
  localparam logic [7:0] TSDR_RING_COUNT_PERIPH_CELL = 8'h09;
  localparam logic [7:0] TSDR_RING_COUNT_PERIPH_WIRE = 8'h0A;
  localparam logic [7:0] TSDR_DEBUG_SAVED_STATUS = 8'h10;
  localparam logic [7:0] TSDR_DEBUG_SAVED_PC = 8'h11;
  localparam logic [7:0] TSDR_DEBUG_SAVED_STACK_PTR = 8'h12;
  localparam logic [7:0] TSDR_STATE_READ_CORE_SELECT = 8'h13;
  localparam logic [7:0] TSDR_STATE_READ_REG_SELECT = 8'h14;
  localparam logic [7:0] TSDR_DEBUG_CAUSE = 8'h15;
  localparam logic [7:0] TSDR_DEBUG_CAUSE_DATA = 8'h16;
  localparam logic [7:0] TSDR_DEBUG_CORE_HOLD = 8'h18;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int TSDR_BOOT_TILE_LSB = 16;
  localparam int TSDR_BOOT_OTP_BIT = 8;
  localparam int TSDR_RING_TILE_EN_BIT = 1;
  localparam int TSDR_RING_PERIPH_EN_BIT = 0;
  localparam int TSDR_CAUSE_BP_LSB = 16;
  localparam int TSDR_CAUSE_CORE_LSB = 8;
  localparam int TSDR_RING_COUNT_W = 16;
  localparam int TSDR_RING_NUM = 4;

  // ----------------------------------------------------------------------
  // debug cause codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] TSDR_CAUSE_NONE = 3'h0;
  localparam logic [2:0] TSDR_CAUSE_HOST = 3'h1;
  localparam logic [2:0] TSDR_CAUSE_DEBUG_CALL = 3'h2;
  localparam logic [2:0] TSDR_CAUSE_INSN_BP = 3'h3;
  localparam logic [2:0] TSDR_CAUSE_DATA_WP = 3'h4;
  localparam logic [2:0] TSDR_CAUSE_RES_WP = 3'h5;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] TSDR_RING_CTRL_RST = 2'h0;
  localparam logic [7:0] TSDR_CORE_HOLD_RST = 8'h00;
  // clock edges after reset release before the synchronised pins settle
  localparam logic [1:0] TSDR_MODE_SETTLE = 2'h2;

endpackage : tsdr_pkg

// [tsdr_regs.sv]
// tile status and debug register bank, reached by processor status
// reads and writes from the core; one clock, synchronous reset
// assumes debug entry information arrives as a one-cycle pulse from the
// core and the oscillator outputs are raw asynchronous levels
//
// Behaviour
// - boot status is read-only; bits 23:16 give this tile's switch number
// - boot status bit 8 reads 1 when boot from OTP is enabled
// - boot status bits 7:0 show the sampled boot mode pins
// - security register reads a read-only copy of the OTP security word
// - four free-running oscillators each clock a counter, gated by control
// - control bit 1 enables tile oscillators, bit 0 peripheral; reset 0
// - oscillators run asynchronous to the tile clock, a random source
// - counters at 0x07..0x0A return 16-bit counts in bits 15:0
// - oscillator counts survive a system reset
// - debug entry captures the saved status register into 0x10
// - debug entry captures saved pc into 0x11, stack pointer into 0x12
// - debugger writes state-read core in 7:0, register index in 4:0
// - cause bits 2:0 encode host, call, breakpoint, data, resource
// - bits 17:16 hold lowest triggering breakpoint or watchpoint number
// - bits 15:8 hold causing logical core, else zero
// - cause data holds address on data, resource id on resource watch
// - core hold mask bits stop their cores outside debug mode
// - registers are reached by number with processor status accesses
`timescale 1ns/10ps
`default_nettype none

module tsdr_regs (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // processor status access port
  input wire logic ps_rd_i,
  input wire logic ps_wr_i,
  input wire logic [7:0] ps_addr_i,
  input wire logic [31:0] ps_wdata_i,
  output logic [31:0] ps_rdata_o,
  output logic ps_rvalid_o,
  // tile identity and boot
  input wire logic [7:0] tile_number_i,
  input wire logic otp_boot_en_i,
  input wire logic [7:0] boot_mode_pins_i,
  input wire logic [31:0] security_word_i,
  // ring oscillators
  input wire logic [tsdr_pkg::TSDR_RING_NUM-1:0] ring_osc_i,
  output logic [tsdr_pkg::TSDR_RING_NUM-1:0] ring_osc_en_o,
  // debug entry from the core
  input wire logic debug_mode_i,
  input wire logic debug_entry_i,
  input wire logic [2:0] debug_cause_i,
  input wire logic debug_core_valid_i,
  input wire logic [7:0] debug_core_i,
  input wire logic [3:0] debug_hits_i,
  input wire logic [31:0] debug_hit_data_i,
  input wire logic [31:0] saved_status_register_i,
  input wire logic [31:0] saved_program_counter_i,
  input wire logic [31:0] saved_stack_pointer_i,
  // state read operands and core hold
  output logic [7:0] state_read_core_o,
  output logic [4:0] state_read_reg_o,
  output logic [7:0] core_hold_o
);
  import tsdr_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode_meta;
    logic [7:0] mode_sync;
    logic [1:0] mode_wait;
    logic [7:0] boot_mode;
    logic [TSDR_RING_NUM-1:0] osc_meta;
    logic [TSDR_RING_NUM-1:0] osc_sync;
    logic [TSDR_RING_NUM-1:0] osc_prev;
    logic [1:0] ring_ctrl;
    logic [TSDR_RING_NUM-1:0][TSDR_RING_COUNT_W-1:0] ring_count;
    logic [31:0] saved_status;
    logic [31:0] saved_pc;
    logic [31:0] saved_sp;
    logic [7:0] core_sel;
    logic [4:0] reg_sel;
    logic [2:0] cause;
    logic [7:0] cause_core;
    logic [1:0] cause_bp;
    logic [31:0] cause_data;
    logic [7:0] hold;
    logic [31:0] rdata;
    logic rvalid;
  } tsdr_state_t;

  // power-up value: the counters have no reset, so they need a known start
  tsdr_state_t state = '0;
  tsdr_state_t next_state;

  // lowest set hit wins when several fire together
  function automatic logic [1:0] tsdr_lowest_hit(input logic [3:0] hits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (hits[k]) begin
        idx = 2'(k);
      end
    end
    return idx;
  endfunction : tsdr_lowest_hit

  logic [TSDR_RING_NUM-1:0] ring_en;
  logic wr_dbg;

  // tile pair (0,1) on bit 1, peripheral pair (2,3) on bit 0
  assign ring_en = {{2{state.ring_ctrl[TSDR_RING_PERIPH_EN_BIT]}},
                    {2{state.ring_ctrl[TSDR_RING_TILE_EN_BIT]}}};
  assign wr_dbg = ps_wr_i && debug_mode_i;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    // pins and oscillators are asynchronous: two flops before any use
    next_state.mode_meta = boot_mode_pins_i;
    next_state.mode_sync = state.mode_meta;
    next_state.osc_meta = ring_osc_i;
    next_state.osc_sync = state.osc_meta;
    next_state.osc_prev = state.osc_sync;

    // boot pins are caught once, after the synchroniser has filled
    if (state.mode_wait != TSDR_MODE_SETTLE) begin
      next_state.mode_wait = state.mode_wait + 2'h1;
    end
    if (state.mode_wait == (TSDR_MODE_SETTLE - 2'h1)) begin
      next_state.boot_mode = state.mode_sync;
    end

    // each counter advances on a rising oscillator edge while enabled;
    // counts above half the tile clock rate alias, fine for entropy
    for (int i = 0; i < TSDR_RING_NUM; i++) begin
      if (ring_en[i] && state.osc_sync[i] && !state.osc_prev[i]) begin
        next_state.ring_count[i] = state.ring_count[i] + 16'h0001;
      end
    end

    // reads answer one cycle later; unmapped numbers read zero
    next_state.rvalid = ps_rd_i;
    next_state.rdata = 32'h0000_0000;
    if (ps_rd_i) begin
      if (ps_addr_i == TSDR_TILE_BOOT_STATUS) begin
        next_state.rdata[TSDR_BOOT_TILE_LSB +: 8] = tile_number_i;
        next_state.rdata[TSDR_BOOT_OTP_BIT] = otp_boot_en_i;
        next_state.rdata[7:0] = state.boot_mode;
      end else if (ps_addr_i == TSDR_SECURITY_WORD_COPY) begin
        next_state.rdata = security_word_i;
      end else if (ps_addr_i == TSDR_RING_OSC_CONTROL) begin
        next_state.rdata[1:0] = state.ring_ctrl;
      end else if (ps_addr_i == TSDR_RING_COUNT_TILE_CELL) begin
        next_state.rdata[15:0] = state.ring_count[0];
      end else if (ps_addr_i == TSDR_RING_COUNT_TILE_WIRE) begin
        next_state.rdata[15:0] = state.ring_count[1];
      end else if (ps_addr_i == TSDR_RING_COUNT_PERIPH_CELL) begin
        next_state.rdata[15:0] = state.ring_count[2];
      end else if (ps_addr_i == TSDR_RING_COUNT_PERIPH_WIRE) begin
        next_state.rdata[15:0] = state.ring_count[3];
      end else if (ps_addr_i == TSDR_DEBUG_SAVED_STATUS) begin
        next_state.rdata = state.saved_status;
      end else if (ps_addr_i == TSDR_DEBUG_SAVED_PC) begin
        next_state.rdata = state.saved_pc;
      end else if (ps_addr_i == TSDR_DEBUG_SAVED_STACK_PTR) begin
        next_state.rdata = state.saved_sp;
      end else if (ps_addr_i == TSDR_STATE_READ_CORE_SELECT) begin
        next_state.rdata[7:0] = state.core_sel;
      end else if (ps_addr_i == TSDR_STATE_READ_REG_SELECT) begin
        next_state.rdata[4:0] = state.reg_sel;
      end else if (ps_addr_i == TSDR_DEBUG_CAUSE) begin
        next_state.rdata[TSDR_CAUSE_BP_LSB +: 2] = state.cause_bp;
        next_state.rdata[TSDR_CAUSE_CORE_LSB +: 8] = state.cause_core;
        next_state.rdata[2:0] = state.cause;
      end else if (ps_addr_i == TSDR_DEBUG_CAUSE_DATA) begin
        next_state.rdata = state.cause_data;
      end else if (ps_addr_i == TSDR_DEBUG_CORE_HOLD) begin
        next_state.rdata[7:0] = state.hold;
      end
    end

    // writes; read-only and reserved bits simply drop
    if (ps_wr_i && ps_addr_i == TSDR_RING_OSC_CONTROL) begin
      next_state.ring_ctrl = ps_wdata_i[1:0];
    end
    if (wr_dbg) begin
      if (ps_addr_i == TSDR_DEBUG_SAVED_PC) begin
        next_state.saved_pc = ps_wdata_i;
      end else if (ps_addr_i == TSDR_DEBUG_SAVED_STACK_PTR) begin
        next_state.saved_sp = ps_wdata_i;
      end else if (ps_addr_i == TSDR_STATE_READ_CORE_SELECT) begin
        next_state.core_sel = ps_wdata_i[7:0];
      end else if (ps_addr_i == TSDR_STATE_READ_REG_SELECT) begin
        next_state.reg_sel = ps_wdata_i[4:0];
      end else if (ps_addr_i == TSDR_DEBUG_CAUSE) begin
        next_state.cause_bp = ps_wdata_i[TSDR_CAUSE_BP_LSB +: 2];
        next_state.cause_core = ps_wdata_i[TSDR_CAUSE_CORE_LSB +: 8];
        next_state.cause = ps_wdata_i[2:0];
      end else if (ps_addr_i == TSDR_DEBUG_CAUSE_DATA) begin
        next_state.cause_data = ps_wdata_i;
      end else if (ps_addr_i == TSDR_DEBUG_CORE_HOLD) begin
        next_state.hold = ps_wdata_i[7:0];
      end
    end

    // debug entry is placed after the writes so it wins over a same-cycle write
    if (debug_entry_i) begin
      next_state.saved_status = saved_status_register_i;
      next_state.saved_pc = saved_program_counter_i;
      next_state.saved_sp = saved_stack_pointer_i;
      next_state.cause = debug_cause_i;
      next_state.cause_core = debug_core_valid_i ? debug_core_i
                                                 : 8'h00;
      next_state.cause_bp = 2'h0;
      if (debug_cause_i == TSDR_CAUSE_INSN_BP ||
          debug_cause_i == TSDR_CAUSE_DATA_WP ||
          debug_cause_i == TSDR_CAUSE_RES_WP) begin
        next_state.cause_bp = tsdr_lowest_hit(debug_hits_i);
      end
      if (debug_cause_i == TSDR_CAUSE_DATA_WP ||
          debug_cause_i == TSDR_CAUSE_RES_WP) begin
        next_state.cause_data = debug_hit_data_i;
      end
    end

    // counters stay out of reset so their entropy survives it
    if (sys_rst_i) begin
      next_state = '0;
      // the pin synchroniser keeps running so the pins are ready at release
      next_state.mode_meta = boot_mode_pins_i;
      next_state.mode_sync = state.mode_meta;
      next_state.ring_ctrl = TSDR_RING_CTRL_RST;
      next_state.hold = TSDR_CORE_HOLD_RST;
      next_state.ring_count = state.ring_count;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign ps_rdata_o = state.rdata;
  assign ps_rvalid_o = state.rvalid;
  assign ring_osc_en_o = ring_en;
  assign state_read_core_o = state.core_sel;
  assign state_read_reg_o = state.reg_sel;
  // the mask only bites outside debug mode, which gives single stepping
  assign core_hold_o = debug_mode_i ? 8'h00 : state.hold;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking tsdr_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_boot_tile;
    ps_rd_i && ps_addr_i == TSDR_TILE_BOOT_STATUS |=>
      ps_rvalid_o && ps_rdata_o[23:16] == $past(tile_number_i) &&
      ps_rdata_o[31:24] == 8'h00;
  endproperty
  a_boot_tile: assert property (p_boot_tile)
    else $error("boot status tile number wrong");

  property p_boot_otp;
    ps_rd_i && ps_addr_i == TSDR_TILE_BOOT_STATUS |=>
      ps_rdata_o[8] == $past(otp_boot_en_i) && ps_rdata_o[15:9] == 7'h00;
  endproperty
  a_boot_otp: assert property (p_boot_otp)
    else $error("boot status otp bit wrong");

  property p_boot_mode;
    ps_rd_i && ps_addr_i == TSDR_TILE_BOOT_STATUS |=>
      ps_rdata_o[7:0] == $past(state.boot_mode);
  endproperty
  a_boot_mode: assert property (p_boot_mode)
    else $error("boot mode field wrong");

  property p_security;
    ps_rd_i && ps_addr_i == TSDR_SECURITY_WORD_COPY |=>
      ps_rdata_o == $past(security_word_i);
  endproperty
  a_security: assert property (p_security)
    else $error("security copy wrong");

  property p_ring_ctrl;
    ps_wr_i && ps_addr_i == TSDR_RING_OSC_CONTROL |=>
      ring_osc_en_o[1:0] == {2{$past(ps_wdata_i[1])}} &&
      ring_osc_en_o[3:2] == {2{$past(ps_wdata_i[0])}};
  endproperty
  a_ring_ctrl: assert property (p_ring_ctrl)
    else $error("oscillator enables do not follow control write");

  property p_ring_frozen;
    !ring_osc_en_o[0] |=> $stable(state.ring_count[0]);
  endproperty
  a_ring_frozen: assert property (p_ring_frozen)
    else $error("stopped oscillator counter moved");

  property p_ring_read;
    ps_rd_i && ps_addr_i == TSDR_RING_COUNT_PERIPH_WIRE |=>
      ps_rdata_o == {16'h0000, $past(state.ring_count[3])};
  endproperty
  a_ring_read: assert property (p_ring_read)
    else $error("oscillator count readback wrong");

  property p_entry_regs;
    debug_entry_i |=> state.saved_status == $past(saved_status_register_i)
      && state.saved_pc == $past(saved_program_counter_i)
      && state.saved_sp == $past(saved_stack_pointer_i);
  endproperty
  a_entry_regs: assert property (p_entry_regs)
    else $error("saved context not captured on debug entry");

  property p_entry_cause;
    debug_entry_i |=> state.cause == $past(debug_cause_i) &&
      state.cause_core == ($past(debug_core_valid_i) ? $past(debug_core_i)
                                                     : 8'h00);
  endproperty
  a_entry_cause: assert property (p_entry_cause)
    else $error("debug cause or core field wrong");

  property p_entry_bp;
    debug_entry_i && debug_cause_i == TSDR_CAUSE_DATA_WP |=>
      state.cause_bp == tsdr_lowest_hit($past(debug_hits_i)) &&
      state.cause_data == $past(debug_hit_data_i);
  endproperty
  a_entry_bp: assert property (p_entry_bp)
    else $error("watchpoint number or data wrong");

  property p_dbg_guard;
    ps_wr_i && !debug_mode_i && !debug_entry_i &&
      ps_addr_i == TSDR_DEBUG_CORE_HOLD |=> $stable(state.hold);
  endproperty
  a_dbg_guard: assert property (p_dbg_guard)
    else $error("debug register written outside debug mode");

  property p_hold;
    !debug_mode_i && state.hold[0] |-> core_hold_o[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("held core not stopped");

  property p_rd_answer;
    ps_rd_i |=> ps_rvalid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered one cycle later");

  property p_rd_idle;
    !ps_rd_i |=> !ps_rvalid_o && ps_rdata_o == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data or valid without a read");

  property p_ring_cell_read;
    ps_rd_i && ps_addr_i == TSDR_RING_COUNT_TILE_CELL |=>
      ps_rdata_o == {16'h0000, $past(state.ring_count[0])};
  endproperty
  a_ring_cell_read: assert property (p_ring_cell_read)
    else $error("tile cell count readback wrong");

  // reset must be watched here, so the default disable is overridden
  property p_ring_keep;
    disable iff (1'b0)
    sys_rst_i |=> $stable(state.ring_count);
  endproperty
  a_ring_keep: assert property (p_ring_keep)
    else $error("oscillator count lost in reset");

  property p_ctrl_reset;
    disable iff (1'b0)
    sys_rst_i |=> ring_osc_en_o == 4'h0 && !ps_rvalid_o;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("oscillator enables not cleared by reset");

endmodule : tsdr_regs

`default_nettype wire

// [tsdr_ring_model.sv]
// behavioural ring oscillators standing behind the status bank
// assumes the bank drives one enable per oscillator, same bit order
`timescale 1ns/10ps
`default_nettype none

module tsdr_ring_model (
  input wire logic [3:0] en_i,
  output wire logic [3:0] osc_o,
  output wire logic [3:0][15:0] rises_o
);
  // ----------------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------------
  // half periods are 230, 270, 310 and 350 ns, only the last a multiple of the tile clock; every level lasts
  // over four and a half tile clocks so the bank can count each edge
  for (genvar g = 0; g < 4; g++) begin : g_osc
    logic o;
    logic [15:0] n;
    assign osc_o[g] = o;
    assign rises_o[g] = n;
    initial begin
      o = 1'b0;
      n = 16'h0000;
      forever begin
        #(230 + 40 * g);
        // stands still while stopped, free running while enabled
        if (en_i[g] === 1'b1) begin
          o = ~o;
          if (o) begin
            n = n + 16'h0001;
          end
        end
      end
    end
  end
endmodule : tsdr_ring_model

`default_nettype wire

// [tb_tile_status_debug_regs.sv]
// self-checking bench for the tile status and debug register bank
// assumes the bank answers reads one cycle later with a one-cycle valid
`timescale 1ns/10ps
`default_nettype none

module tb_tile_status_debug_regs;
  import tsdr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ps_rd_i = 1'b0;
  logic ps_wr_i = 1'b0;
  logic [7:0] ps_addr_i = 8'h00;
  logic [31:0] ps_wdata_i = 32'h0;
  logic [31:0] ps_rdata_o;
  logic ps_rvalid_o;
  logic [3:0] osc;
  logic [3:0] osc_en;
  logic [3:0][15:0] rises;
  logic debug_mode_i = 1'b0;
  logic debug_entry_i = 1'b0;
  logic otp_en = 1'b1;
  logic [2:0] k = 3'h0;
  logic [7:0] st_core;
  logic [4:0] st_reg;
  logic [7:0] hold;
  logic [2:0] cs [5] = '{3'h4, 3'h1, 3'h5, 3'h2, 3'h3};
  logic [3:0] hits [5] = '{4'hA, 4'h8, 4'h9, 4'h6, 4'hC};
  logic [31:0] d;
  logic [31:0] exp_data;
  logic [15:0] cnt [4];
  int failures = 0;
  int checks = 0;
  int cyc = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  tsdr_regs u_tsdr_regs (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .ps_rd_i(ps_rd_i), .ps_wr_i(ps_wr_i), .ps_addr_i(ps_addr_i),
    .ps_wdata_i(ps_wdata_i), .ps_rdata_o(ps_rdata_o),
    .ps_rvalid_o(ps_rvalid_o), .tile_number_i(8'h5A),
    .otp_boot_en_i(otp_en), .boot_mode_pins_i(8'hC3),
    .security_word_i(32'hA5C3_1E69), .ring_osc_i(osc),
    .ring_osc_en_o(osc_en), .debug_mode_i(debug_mode_i),
    .debug_entry_i(debug_entry_i), .debug_cause_i(cs[k]),
    .debug_core_valid_i(k[0]), .debug_core_i({5'h08, k}),
    .debug_hits_i(hits[k]), .debug_hit_data_i({29'h1A000000, k}),
    .saved_status_register_i({29'h0AA00000, k}),
    .saved_program_counter_i({29'h0CC00000, k}),
    .saved_stack_pointer_i({29'h0EE00000, k}),
    .state_read_core_o(st_core), .state_read_reg_o(st_reg),
    .core_hold_o(hold));

  tsdr_ring_model u_tsdr_ring_model (
    .en_i(osc_en), .osc_o(osc), .rises_o(rises));

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk

  task automatic ps_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    ps_wr_i <= 1'b1;
    ps_addr_i <= a;
    ps_wdata_i <= v;
    @(posedge ref_clk_i);
    ps_wr_i <= 1'b0;
    #1;
  endtask : ps_wr

  task automatic ps_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    ps_rd_i <= 1'b1;
    ps_addr_i <= a;
    @(posedge ref_clk_i);
    ps_rd_i <= 1'b0;
    #1;
    chk({31'h0, ps_rvalid_o}, 32'h1);
    v = ps_rdata_o;
  endtask : ps_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ps_rd(a, v);
    chk(v, e);
  endtask : rd_chk

  function automatic logic [1:0] lowest(input logic [3:0] h);
    for (int i = 3; i >= 0; i--) begin
      if (h[i]) begin
        lowest = 2'(i);
      end
    end
  endfunction : lowest

  // stopped-before-read runs; one edge may die in the synchroniser as the
  // enable falls, so the bank may trail the model by one count
  task automatic ring_run(input logic [1:0] v);
    logic [15:0] b [4];
    logic [15:0] m [4];
    logic [15:0] x;
    logic [31:0] r;
    for (int j = 0; j < 4; j++) begin
      ps_rd(8'(7 + j), r);
      b[j] = r[15:0];
      m[j] = rises[j];
    end
    ps_wr(TSDR_RING_OSC_CONTROL, {30'h3FFFFFFF, v});
    #1;
    chk({28'h0, osc_en}, {28'h0, {2{v[0]}}, {2{v[1]}}});
    rd_chk(TSDR_RING_OSC_CONTROL, {30'h0, v});
    repeat (300) @(posedge ref_clk_i);
    ps_wr(TSDR_RING_OSC_CONTROL, 32'h0);
    repeat (10) @(posedge ref_clk_i);
    for (int j = 0; j < 4; j++) begin
      ps_rd(8'(7 + j), r);
      chk({16'h0, r[31:16]}, 32'h0);
      x = (rises[j] - m[j]) - (r[15:0] - b[j]);
      chk({31'h0, x !== 16'h0 && x !== 16'h1}, 32'h0);
    end
  endtask : ring_run

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask : do_reset

  task automatic test_done();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    rd_chk(TSDR_TILE_BOOT_STATUS, 32'h005A_01C3);
    @(posedge ref_clk_i);
    otp_en <= 1'b0;
    ps_wr(TSDR_TILE_BOOT_STATUS, 32'h0);
    rd_chk(TSDR_TILE_BOOT_STATUS, 32'h005A_00C3);
    ps_wr(TSDR_SECURITY_WORD_COPY, 32'h0);
    rd_chk(TSDR_SECURITY_WORD_COPY, 32'hA5C3_1E69);
    rd_chk(TSDR_RING_OSC_CONTROL, 32'h0);
    rd_chk(8'h04, 32'h0);
    ring_run(2'h2);
    ring_run(2'h1);
    ring_run(2'h3);
    for (int j = 0; j < 4; j++) begin
      ps_rd(8'(7 + j), d);
      cnt[j] = d[15:0];
    end
    @(posedge ref_clk_i);
    do_reset();
    for (int j = 0; j < 4; j++) begin
      rd_chk(8'(7 + j), {16'h0, cnt[j]});
    end
    rd_chk(TSDR_RING_OSC_CONTROL, 32'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk_i);
      k <= 3'(i);
      debug_entry_i <= 1'b1;
      @(posedge ref_clk_i);
      debug_entry_i <= 1'b0;
      if (cs[i] > 3'h3) begin
        exp_data = {29'h1A000000, 3'(i)};
      end
      rd_chk(TSDR_DEBUG_SAVED_STATUS, {29'h0AA00000, 3'(i)});
      rd_chk(TSDR_DEBUG_SAVED_PC, {29'h0CC00000, 3'(i)});
      rd_chk(TSDR_DEBUG_SAVED_STACK_PTR, {29'h0EE00000, 3'(i)});
      rd_chk(TSDR_DEBUG_CAUSE_DATA, exp_data);
      rd_chk(TSDR_DEBUG_CAUSE, {14'h0,
        cs[i] > 3'h2 ? lowest(hits[i]) : 2'h0,
        i % 2 == 1 ? {5'h08, 3'(i)} : 8'h00, 5'h0, cs[i]});
    end
    ps_wr(TSDR_DEBUG_SAVED_PC, 32'h1234_5678);
    rd_chk(TSDR_DEBUG_SAVED_PC, 32'h6600_0004);
    @(posedge ref_clk_i);
    debug_mode_i <= 1'b1;
    ps_wr(TSDR_DEBUG_SAVED_PC, 32'h1234_5678);
    rd_chk(TSDR_DEBUG_SAVED_PC, 32'h1234_5678);
    ps_wr(TSDR_DEBUG_SAVED_STATUS, 32'hFFFF_FFFF);
    rd_chk(TSDR_DEBUG_SAVED_STATUS, 32'h5500_0004);
    ps_wr(TSDR_STATE_READ_CORE_SELECT, 32'hFFFF_FFFF);
    ps_wr(TSDR_STATE_READ_REG_SELECT, 32'hFFFF_FFFF);
    chk({19'h0, st_reg, st_core}, 32'h1FFF);
    rd_chk(TSDR_STATE_READ_CORE_SELECT, 32'hFF);
    rd_chk(TSDR_STATE_READ_REG_SELECT, 32'h1F);
    ps_wr(TSDR_DEBUG_CAUSE, 32'hFFFF_FFFF);
    rd_chk(TSDR_DEBUG_CAUSE, 32'h0003_FF07);
    ps_wr(TSDR_DEBUG_CORE_HOLD, 32'hFFFF_FF05);
    chk({24'h0, hold}, 32'h0);
    rd_chk(TSDR_DEBUG_CORE_HOLD, 32'h05);
    @(posedge ref_clk_i);
    debug_mode_i <= 1'b0;
    #1;
    chk({24'h0, hold}, 32'h05);
    ps_wr(TSDR_DEBUG_CORE_HOLD, 32'h0);
    chk({24'h0, hold}, 32'h05);
    test_done();
  end
endmodule : tb_tile_status_debug_regs

`default_nettype wire
